// ---- logic/pcslm_pkg.sv ----
// Package with constants and types of the 100BASE-X coding and link monitor block.
package pcslm_pkg;
   // ****************************************
   // Register bus
   // ****************************************
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam logic [4:0] REG_CTRL_ADDR = 5'h00;
   localparam logic [4:0] REG_CFG_ADDR = 5'h18;
   localparam logic [4:0] REG_STAT_ADDR = 5'h19;
   localparam int CTRL_LOCAL_LPBK_BIT = 14;
   localparam int CFG_SCRAMBLER_STRAP_INPUT_BIT = 2;
   localparam int CFG_REMOTE_LPBK_BIT = 3;
   localparam logic CFG_SCRAMBLER_STRAP_INPUT_RST = 1'b1;
   localparam int STAT_SD_BIT = 0;
   localparam int STAT_LINK_BIT = 1;
   localparam int STAT_STRAP_BIT = 2;
   localparam int STAT_SCRAM_BIT = 3;
   localparam int STAT_LOCK_BIT = 4;
   // ****************************************
   // Scrambler
   // ****************************************
   localparam int LFSR_W = 11;
   localparam int PHY_ADDR_W = 5;
   localparam logic [5:0] SEED_HIGH = 6'h2a;
   localparam logic [1:0] LOCK_GROUPS = 2'h3;
   // ****************************************
   // Code-groups
   // ****************************************
   localparam logic [4:0] CG_IDLE_CODE = 5'h1f;
   localparam logic [4:0] CG_J_CODE = 5'h18;
   localparam logic [4:0] CG_K_CODE = 5'h11;
   localparam logic [4:0] CG_T_CODE = 5'h0d;
   localparam logic [4:0] CG_R_CODE = 5'h07;
   localparam logic [4:0] CG_H_CODE = 5'h04;
   typedef enum logic [2:0] {
      CG_DATA = 3'b000, CG_IDLE = 3'b001, CG_J = 3'b010, CG_K = 3'b011,
      CG_T = 3'b100, CG_R = 3'b101, CG_H = 3'b110, CG_BAD = 3'b111
   } pcslm_cg_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000, TX_K = 3'b001, TX_DATA = 3'b010, TX_R = 3'b011
   } pcslm_tx_t;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00, RX_J = 2'b01, RX_DATA = 2'b10, RX_T = 2'b11
   } pcslm_rx_t;
   typedef enum logic {
      LINK_FAIL = 1'b0, LINK_PASS = 1'b1
   } pcslm_link_t;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 125;
   localparam int TICK_US = 1;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam int SD_ON_MS = 3;
   localparam int SD_OFF_MS = 1;
   localparam int LINK_QUAL_US = 500;
   localparam int US_PER_MS = 1000;
   localparam int US_CNT_W = 13;
endpackage

// ---- logic/pcslm_core.sv ----
// Per-port 100BASE-X coding, scrambling and link monitor logic.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module pcslm_core
   import pcslm_pkg::*;
#(
   parameter int SD_ON_US = SD_ON_MS * US_PER_MS,
   parameter int SD_OFF_US = SD_OFF_MS * US_PER_MS,
   parameter int QUAL_US = LINK_QUAL_US
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [PHY_ADDR_W-1:0] phy_addr,
   input wire logic scrambler_strap_input,
   input wire logic energy_above_high,
   input wire logic energy_below_low,
   input wire logic fiber_detect_p,
   input wire logic fiber_detect_n,
   input wire logic link_pulse_valid,
   input wire logic fiber_mode,
   input wire logic speed_10,
   input wire logic force_10,
   input wire logic tx_strobe,
   input wire logic tx_en,
   input wire logic tx_er,
   input wire logic [3:0] tx_nibble,
   output logic [4:0] tx_code,
   output logic tx_code_valid,
   output logic tx_link_pulse_only,
   input wire logic rx_strobe,
   input wire logic [4:0] rx_code,
   output logic [3:0] rx_nibble,
   output logic rx_nibble_valid,
   output logic rx_in_stream,
   output logic rx_error,
   output logic energy_detect_flag,
   output logic link_pass
);
   // ****************************************
   // Helper functions
   // ****************************************
   // Advances the generator by one code-group and returns {key, state}.
   function automatic logic [15:0] lfsr_step5(input logic [LFSR_W-1:0] s);
      logic [LFSR_W-1:0] t;
      logic [4:0] k;
      logic b;
      t = s;
      k = 5'h00;
      for (int i = 4; i >= 0; i--) begin
         b = t[10] ^ t[8];
         k[i] = b;
         t = {t[9:0], b};
      end
      return {k, t};
   endfunction

   // Loads the generator from cipher bits received during idle fill.
   function automatic logic [LFSR_W-1:0] lfsr_sync5(input logic [LFSR_W-1:0] s, input logic [4:0] c);
      logic [LFSR_W-1:0] t;
      t = s;
      for (int i = 4; i >= 0; i--) begin
         t = {t[9:0], ~c[i]};
      end
      return t;
   endfunction

   function automatic logic [4:0] encode4b5b(input logic [3:0] n);
      logic [4:0] c;
      case (n)
         4'h0: c = 5'h1e;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0a;
         4'h5: c = 5'h0b;
         4'h6: c = 5'h0e;
         4'h7: c = 5'h0f;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'ha: c = 5'h16;
         4'hb: c = 5'h17;
         4'hc: c = 5'h1a;
         4'hd: c = 5'h1b;
         4'he: c = 5'h1c;
         default: c = 5'h1d;
      endcase
      return c;
   endfunction

   // Returns {kind, nibble}; unlisted codes come back as bad.
   function automatic logic [6:0] decode5b4b(input logic [4:0] c);
      logic [6:0] r;
      r = {CG_BAD, 4'h0};
      for (int n = 0; n < 16; n++) begin
         if (encode4b5b(4'(n)) == c) begin
            r = {CG_DATA, 4'(n)};
         end
      end
      if (c == CG_IDLE_CODE) begin
         r = {CG_IDLE, 4'h0};
      end else if (c == CG_J_CODE) begin
         r = {CG_J, 4'h0};
      end else if (c == CG_K_CODE) begin
         r = {CG_K, 4'h0};
      end else if (c == CG_T_CODE) begin
         r = {CG_T, 4'h0};
      end else if (c == CG_R_CODE) begin
         r = {CG_R, 4'h0};
      end else if (c == CG_H_CODE) begin
         r = {CG_H, 4'h0};
      end
      return r;
   endfunction

   // ****************************************
   // Input synchronisers and strap capture
   // ****************************************
   logic [9:0] sync1_q;
   logic [9:0] sync2_q;
   always_ff @(posedge clk) begin
      sync1_q <= {phy_addr, scrambler_strap_input, energy_above_high, energy_below_low,
                  fiber_detect_p, fiber_detect_n};
      sync2_q <= sync1_q;
   end
   logic [PHY_ADDR_W-1:0] addr_s;
   logic strap_s, hi_s, lo_s, fdp_s, fdn_s, pulse_s1_q, pulse_s2_q;
   assign {addr_s, strap_s, hi_s, lo_s, fdp_s, fdn_s} = sync2_q;
   always_ff @(posedge clk) begin
      pulse_s1_q <= link_pulse_valid;
      pulse_s2_q <= pulse_s1_q;
   end

   logic rst_seen_q, strap_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rst_seen_q <= 1'b0;
         strap_q <= 1'b0;
      end else if (!rst_seen_q) begin
         rst_seen_q <= 1'b1;
         strap_q <= strap_s;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   logic local_lpbk_q, remote_lpbk_q, scrambler_strap_input_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         local_lpbk_q <= 1'b0;
         remote_lpbk_q <= 1'b0;
         scrambler_strap_input_q <= CFG_SCRAMBLER_STRAP_INPUT_RST;
      end else if (reg_we) begin
         if (reg_addr == REG_CTRL_ADDR) begin
            local_lpbk_q <= reg_wdata[CTRL_LOCAL_LPBK_BIT];
         end else if (reg_addr == REG_CFG_ADDR) begin
            scrambler_strap_input_q <= reg_wdata[CFG_SCRAMBLER_STRAP_INPUT_BIT];
            remote_lpbk_q <= reg_wdata[CFG_REMOTE_LPBK_BIT];
         end
      end
   end

   logic scram_active, rx_locked_q;
   logic [DATA_W-1:0] rdata_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= '0;
         if (reg_re) begin
            if (reg_addr == REG_CTRL_ADDR) begin
               rdata_q[CTRL_LOCAL_LPBK_BIT] <= local_lpbk_q;
            end else if (reg_addr == REG_CFG_ADDR) begin
               rdata_q[CFG_SCRAMBLER_STRAP_INPUT_BIT] <= scrambler_strap_input_q;
               rdata_q[CFG_REMOTE_LPBK_BIT] <= remote_lpbk_q;
            end else if (reg_addr == REG_STAT_ADDR) begin
               rdata_q[STAT_SD_BIT] <= energy_detect_flag;
               rdata_q[STAT_LINK_BIT] <= link_pass;
               rdata_q[STAT_STRAP_BIT] <= strap_q;
               rdata_q[STAT_SCRAM_BIT] <= scram_active;
               rdata_q[STAT_LOCK_BIT] <= rx_locked_q;
            end
         end
      end
   end
   assign reg_rdata = rdata_q;

   assign scram_active = strap_q && scrambler_strap_input_q && !fiber_mode && !speed_10 && !force_10;

   // ****************************************
   // Signal detect
   // ****************************************
   logic [6:0] div_q;
   logic tick;
   assign tick = (div_q == 7'(TICK_CYCLES - 1));
   always_ff @(posedge clk) begin
      if (!rst_n || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 7'h01;
      end
   end

   logic [US_CNT_W-1:0] on_cnt_q, off_cnt_q;
   logic sd_tp_q, sd_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         on_cnt_q <= '0;
         off_cnt_q <= '0;
         sd_tp_q <= 1'b0;
      end else begin
         on_cnt_q <= hi_s ? on_cnt_q : '0;
         off_cnt_q <= lo_s ? off_cnt_q : '0;
         if (hi_s && tick) begin
            if (on_cnt_q == US_CNT_W'(SD_ON_US - 1)) begin
               sd_tp_q <= 1'b1;
            end else begin
               on_cnt_q <= on_cnt_q + 1'b1;
            end
         end
         if (lo_s && tick) begin
            if (off_cnt_q == US_CNT_W'(SD_OFF_US - 1)) begin
               sd_tp_q <= 1'b0;
            end else begin
               off_cnt_q <= off_cnt_q + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sd_q <= 1'b0;
      end else if (local_lpbk_q) begin
         sd_q <= 1'b0;
      end else if (remote_lpbk_q) begin
         sd_q <= 1'b1;
      end else if (fiber_mode) begin
         sd_q <= fdp_s && !fdn_s;
      end else begin
         sd_q <= sd_tp_q;
      end
   end
   assign energy_detect_flag = sd_q;

   // ****************************************
   // Link monitor
   // ****************************************
   pcslm_link_t link_q;
   logic [US_CNT_W-1:0] qual_q;
   logic mode_10;
   assign mode_10 = speed_10 || force_10;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link_q <= LINK_FAIL;
         qual_q <= '0;
      end else if (mode_10) begin
         link_q <= pulse_s2_q ? LINK_PASS : LINK_FAIL;
         qual_q <= '0;
      end else begin
         case (link_q)
            LINK_FAIL: begin
               if (!sd_q) begin
                  qual_q <= '0;
               end else if (tick) begin
                  if (qual_q == US_CNT_W'(QUAL_US - 1)) begin
                     link_q <= LINK_PASS;
                  end else begin
                     qual_q <= qual_q + 1'b1;
                  end
               end
            end
            default: begin
               if (!sd_q) begin
                  link_q <= LINK_FAIL;
                  qual_q <= '0;
               end
            end
         endcase
      end
   end
   assign link_pass = (link_q == LINK_PASS);
   assign tx_link_pulse_only = !link_pass;

   // ****************************************
   // Transmit encoder and scrambler
   // ****************************************
   logic [LFSR_W-1:0] tx_lfsr_q;
   logic [15:0] tx_step;
   assign tx_step = lfsr_step5(tx_lfsr_q);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_lfsr_q <= {SEED_HIGH, addr_s};
      end else if (!rst_seen_q) begin
         // seed after reset release
         // A short reset can end before the address synchroniser has settled, so the seed is loaded again here.
         tx_lfsr_q <= {SEED_HIGH, addr_s};
      end else if (tx_strobe) begin
         tx_lfsr_q <= tx_step[LFSR_W-1:0];
      end
   end

   pcslm_tx_t tx_st_q;
   logic [4:0] tx_plain;
   logic [4:0] tx_plain_q;
   always_comb begin
      tx_plain = CG_IDLE_CODE;
      if (link_pass) begin
         case (tx_st_q)
            TX_IDLE: tx_plain = tx_en ? CG_J_CODE : CG_IDLE_CODE;
            TX_K: tx_plain = CG_K_CODE;
            TX_DATA: tx_plain = !tx_en ? CG_T_CODE : (tx_er ? CG_H_CODE : encode4b5b(tx_nibble));
            default: tx_plain = CG_R_CODE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_st_q <= TX_IDLE;
      end else if (!link_pass) begin
         tx_st_q <= TX_IDLE;
      end else if (tx_strobe) begin
         case (tx_st_q)
            TX_IDLE: tx_st_q <= tx_en ? TX_K : TX_IDLE;
            TX_K: tx_st_q <= TX_DATA;
            TX_DATA: tx_st_q <= tx_en ? TX_DATA : TX_R;
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   logic [4:0] tx_code_q;
   logic tx_valid_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_code_q <= CG_IDLE_CODE;
         tx_plain_q <= CG_IDLE_CODE;
         tx_valid_q <= 1'b0;
      end else begin
         tx_valid_q <= tx_strobe;
         if (tx_strobe) begin
            tx_plain_q <= tx_plain;
            tx_code_q <= scram_active ? (tx_plain ^ tx_step[15:11]) : tx_plain;
         end
      end
   end
   assign tx_code = tx_code_q;
   assign tx_code_valid = tx_valid_q;

   // ****************************************
   // Receive descrambler and decoder
   // ****************************************
   logic [LFSR_W-1:0] rx_lfsr_q;
   logic [1:0] lock_cnt_q;
   logic [15:0] rx_step;
   logic [4:0] rx_plain;
   logic [6:0] rx_dec;
   pcslm_cg_t rx_kind;
   assign rx_step = lfsr_step5(rx_lfsr_q);
   assign rx_plain = scram_active ? (rx_code ^ rx_step[15:11]) : rx_code;
   assign rx_dec = decode5b4b(rx_plain);
   assign rx_kind = pcslm_cg_t'(rx_dec[6:4]);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_lfsr_q <= {SEED_HIGH, addr_s};
         lock_cnt_q <= '0;
         rx_locked_q <= 1'b0;
      end else if (!rst_seen_q) begin
         rx_lfsr_q <= {SEED_HIGH, addr_s};
      end else if (!scram_active || !link_pass) begin
         lock_cnt_q <= '0;
         rx_locked_q <= 1'b0;
      end else if (rx_strobe) begin
         if (rx_locked_q) begin
            rx_lfsr_q <= rx_step[LFSR_W-1:0];
         end else begin
            // Idle fill reveals the key stream, which seeds the generator.
            rx_lfsr_q <= lfsr_sync5(rx_lfsr_q, rx_code);
            lock_cnt_q <= lock_cnt_q + 2'h1;
            rx_locked_q <= (lock_cnt_q == LOCK_GROUPS - 2'h1);
         end
      end
   end

   pcslm_rx_t rx_st_q;
   logic [3:0] rx_nib_q;
   logic rx_nv_q, rx_err_q;
   logic rx_go;
   assign rx_go = rx_strobe && link_pass && (rx_locked_q || !scram_active);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_st_q <= RX_IDLE;
         rx_nib_q <= 4'h0;
         rx_nv_q <= 1'b0;
         rx_err_q <= 1'b0;
      end else begin
         rx_nv_q <= 1'b0;
         rx_err_q <= 1'b0;
         if (!link_pass) begin
            rx_st_q <= RX_IDLE;
         end else if (rx_go) begin
            case (rx_st_q)
               RX_IDLE: begin
                  if (rx_kind == CG_J) begin
                     rx_st_q <= RX_J;
                  end else if (rx_kind != CG_IDLE) begin
                     rx_err_q <= 1'b1;
                  end
               end
               RX_J: begin
                  rx_st_q <= (rx_kind == CG_K) ? RX_DATA : RX_IDLE;
                  rx_err_q <= (rx_kind != CG_K);
               end
               RX_DATA: begin
                  if (rx_kind == CG_DATA) begin
                     rx_nib_q <= rx_dec[3:0];
                     rx_nv_q <= 1'b1;
                  end else if (rx_kind == CG_T) begin
                     rx_st_q <= RX_T;
                  end else begin
                     rx_err_q <= 1'b1;
                     rx_st_q <= (rx_kind == CG_IDLE) ? RX_IDLE : RX_DATA;
                  end
               end
               default: begin
                  rx_st_q <= RX_IDLE;
                  rx_err_q <= (rx_kind != CG_R);
               end
            endcase
         end
      end
   end
   assign rx_nibble = rx_nib_q;
   assign rx_nibble_valid = rx_nv_q;
   assign rx_error = rx_err_q;
   assign rx_in_stream = (rx_st_q == RX_DATA) || (rx_st_q == RX_T);

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence tx_open_s;
      tx_strobe && link_pass && tx_st_q == TX_IDLE && tx_en;
   endsequence
   sequence tx_k_s;
      tx_strobe && link_pass && tx_st_q == TX_K;
   endsequence

   seed_load_a: assert property (rst_n && !rst_seen_q |=> tx_lfsr_q == {SEED_HIGH, $past(addr_s)})
      else $error("scrambler seed not loaded from address");
   strap_hold_a: assert property (rst_seen_q && $past(rst_seen_q) |-> $stable(strap_q))
      else $error("strap changed after reset release");
   strap_off_a: assert property (tx_strobe && !strap_q |=> tx_code_q == tx_plain_q)
      else $error("scrambling with strap low");
   sd_local_a: assert property (local_lpbk_q |=> !sd_q)
      else $error("signal detect high in local loopback");
   sd_remote_a: assert property (remote_lpbk_q && !local_lpbk_q |=> sd_q)
      else $error("signal detect low in remote loopback");
   sd_rise_a: assert property ($rose(sd_tp_q) |-> $past(hi_s) && $past(on_cnt_q) == US_CNT_W'(SD_ON_US - 1))
      else $error("signal detect rose early");
   sd_fall_a: assert property ($fell(sd_tp_q) |-> $past(lo_s) && $past(off_cnt_q) == US_CNT_W'(SD_OFF_US - 1))
      else $error("signal detect fell early");
   link_drop_a: assert property (link_pass && !mode_10 && !sd_q |=> !link_pass)
      else $error("link stayed up without signal");
   stream_open_a: assert property (tx_open_s |=> tx_plain_q == CG_J_CODE && tx_st_q == TX_K)
      else $error("J did not open the stream");
   stream_k_a: assert property (tx_k_s |=> tx_plain_q == CG_K_CODE)
      else $error("K did not follow J");
   tx_error_a: assert property (tx_strobe && link_pass && tx_st_q == TX_DATA && tx_en && tx_er
                                |=> tx_plain_q == CG_H_CODE)
      else $error("transmit error not coded as H");
   bad_code_a: assert property (rx_go && rx_st_q == RX_DATA && rx_plain == 5'h00 |=> rx_err_q)
      else $error("invalid code-group not flagged");
endmodule
`default_nettype wire

// ---- dv/pcslm_far_end.sv ----
// Far-end link partner model: line energy, fiber detect and received code-groups.
`timescale 1ns/10ps
`default_nettype none
module pcslm_far_end (
   input wire logic clk,
   input wire logic energy_on,
   output logic energy_above_high,
   output logic energy_below_low,
   output logic fiber_detect_p,
   output logic fiber_detect_n,
   output logic rx_strobe,
   output logic [4:0] rx_code
);
   logic [4:0] code_q[$];
   int phase = 0;
   assign fiber_detect_p = energy_on;
   assign fiber_detect_n = !energy_on;
   assign energy_above_high = energy_on;
   assign energy_below_low = !energy_on;
   initial begin
      rx_strobe = 1'b0;
      rx_code = 5'h1f;
   end
   task automatic send(input logic [4:0] code);
      code_q.push_back(code);
   endtask
   always @(posedge clk) begin
      phase <= (phase + 1) % 5;
      rx_strobe <= (phase == 0);
      if (phase == 0) begin
         rx_code <= (code_q.size() != 0) ? code_q.pop_front() : 5'h1f;
      end else begin
         rx_code <= ~rx_code;
      end
   end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the coding and link monitor block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pcslm_pkg::*;
   logic clk, rst_n, reg_we, reg_re, strap, lpv, fib, sp10, f10, tx_strobe, tx_en, tx_er, energy_on, chk_tx;
   logic tx_code_valid, lpo, rx_strobe, rx_nv, rx_in_stream, rx_error, sd, link_pass, eh, el, fp, fn;
   logic [4:0] reg_addr, phy_addr, tx_code, rx_code, x, e, ua;
   logic [15:0] reg_wdata, reg_rdata, rd, seed;
   logic [3:0] tx_nibble, rx_nibble;
   logic [5:0] txq[$];
   logic [4:0] exp_tx[$];
   logic [3:0] exp_rx[$];
   int bad_count = 0, comparisons = 0, ts = 0, phase = 0, errs = 0;
   logic [4:0] cg_tab[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   pcslm_core #(.SD_ON_US(4), .SD_OFF_US(3), .QUAL_US(2)) dut_u (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .phy_addr(phy_addr), .scrambler_strap_input(strap), .energy_above_high(eh), .energy_below_low(el),
      .fiber_detect_p(fp), .fiber_detect_n(fn), .link_pulse_valid(lpv), .fiber_mode(fib), .speed_10(sp10),
      .force_10(f10), .tx_strobe(tx_strobe), .tx_en(tx_en), .tx_er(tx_er), .tx_nibble(tx_nibble),
      .tx_code(tx_code), .tx_code_valid(tx_code_valid), .tx_link_pulse_only(lpo), .rx_strobe(rx_strobe),
      .rx_code(rx_code), .rx_nibble(rx_nibble), .rx_nibble_valid(rx_nv), .rx_in_stream(rx_in_stream),
      .rx_error(rx_error), .energy_detect_flag(sd), .link_pass(link_pass));
   pcslm_far_end far_u (.clk(clk), .energy_on(energy_on), .energy_above_high(eh), .energy_below_low(el),
      .fiber_detect_p(fp), .fiber_detect_n(fn), .rx_strobe(rx_strobe), .rx_code(rx_code));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic rdr(input logic [4:0] a);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 rd = reg_rdata;
      @(posedge clk);
   endtask
   task automatic wait_for(ref logic sig, input logic val, input int lim, input string what);
      int n = 0;
      while (sig !== val && n < lim) begin
         @(posedge clk);
         n++;
      end
      check(what, val, sig);
   endtask
   task automatic print_verdict();
      if (bad_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      phase <= (phase + 1) % 5;
      tx_strobe <= (phase == 0);
      if (phase == 0) begin
         {tx_en, tx_er, tx_nibble} <= (txq.size() != 0) ? txq.pop_front() : 6'h00;
      end
      if (tx_strobe === 1'b1 && rst_n === 1'b1) begin
         case (ts)
            0: x = tx_en ? 5'h18 : 5'h1f;
            1: x = 5'h11;
            2: x = !tx_en ? 5'h0d : (tx_er ? 5'h04 : cg_tab[tx_nibble]);
            default: x = 5'h07;
         endcase
         ts = (ts == 0) ? int'(tx_en) : (ts == 2 && tx_en) ? 2 : (ts + 1) % 4;
         exp_tx.push_back(x);
      end
      if (tx_code_valid === 1'b1 && exp_tx.size() != 0) begin
         e = exp_tx.pop_front();
         if (chk_tx) check("tx_code", e, tx_code);
      end
      if (rx_nv === 1'b1) begin
         check("rx_nibble", (exp_rx.size() != 0) ? exp_rx.pop_front() : 4'hx, rx_nibble);
         check("rx_in_stream", 1, rx_in_stream);
      end
      if (rx_error === 1'b1) errs++;
   end
   initial begin
      #(20000 * 8);
      bad_count++;
      print_verdict();
   end
   initial begin
      {rst_n, reg_we, reg_re, lpv, fib, sp10, f10, energy_on, chk_tx} = '0;
      {reg_addr, reg_wdata} = '0;
      seed = 16'd37711;
      phy_addr = seed[4:0];
      strap = 1'b1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      strap <= 1'b0;
      rdr(REG_CFG_ADDR);
      check("cfg_reset", 16'h0004, rd);
      rdr(REG_STAT_ADDR);
      check("strap_held", 1, rd[STAT_STRAP_BIT]);
      check("scram_on", 1, rd[STAT_SCRAM_BIT]);
      for (int m = 0; m < 4; m++) begin
         seed = lfsr(seed);
         strap <= seed[3];
         {fib, sp10, f10} <= (m == 3) ? 3'b000 : ((3'b100 >> m) | seed[2:0]);
         if (m == 3) wr(REG_CFG_ADDR, {seed[15:4], 4'h0});
         repeat (3) @(posedge clk);
         rdr(REG_STAT_ADDR);
         check("scram_mode", 0, rd[STAT_SCRAM_BIT]);
      end
      strap <= 1'b0;
      seed = lfsr(seed);
      ua = {1'b0, seed[3:0]} | 5'h01;
      wr(ua, seed);
      rdr(ua);
      check("unmapped", 0, rd);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("link_fail", 1, lpo);
      energy_on <= 1'b1;
      repeat (365) @(posedge clk);
      check("sd_early", 0, sd);
      wait_for(sd, 1'b1, 300, "sd_on");
      wait_for(link_pass, 1'b1, 400, "link_on");
      @(posedge clk);
      check("pulse_only", 0, lpo);
      chk_tx = 1'b1;
      txq.push_back(6'h20);
      txq.push_back(6'h20);
      far_u.send(5'h18);
      far_u.send(5'h11);
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         txq.push_back({1'b1, i == 6, seed[3:0]});
         exp_rx.push_back(seed[7:4]);
         far_u.send(cg_tab[seed[7:4]]);
      end
      far_u.send(5'h0d);
      far_u.send(5'h07);
      repeat (90) @(posedge clk);
      check("rx_left", 0, exp_rx.size());
      check("rx_clean", 0, errs);
      check("rx_idle", 0, rx_in_stream);
      far_u.send(5'h18);
      far_u.send(5'h11);
      far_u.send(5'h00);
      repeat (40) @(posedge clk);
      check("rx_bad", 1, errs != 0);
      wr(REG_CTRL_ADDR, 16'h4000);
      check("sd_local", 0, sd);
      wr(REG_CTRL_ADDR, 16'h0000);
      energy_on <= 1'b0;
      wr(REG_CFG_ADDR, {seed[15:4], 4'hc});
      repeat (700) @(posedge clk);
      check("sd_remote", 1, sd);
      energy_on <= 1'b1;
      wr(REG_CFG_ADDR, {seed[15:4], 4'h4});
      repeat (700) @(posedge clk);
      check("sd_back", 1, sd);
      energy_on <= 1'b0;
      repeat (240) @(posedge clk);
      check("sd_hold", 1, sd);
      wait_for(sd, 1'b0, 300, "sd_drop");
      wait_for(link_pass, 1'b0, 20, "link_drop");
      fib <= 1'b1;
      energy_on <= 1'b1;
      wait_for(sd, 1'b1, 6, "sd_fiber_on");
      energy_on <= 1'b0;
      wait_for(sd, 1'b0, 6, "sd_fiber_off");
      fib <= 1'b0;
      sp10 <= 1'b1;
      lpv <= 1'b1;
      wait_for(link_pass, 1'b1, 10, "link_10_on");
      lpv <= 1'b0;
      wait_for(link_pass, 1'b0, 10, "link_10_off");
      print_verdict();
   end
endmodule
`default_nettype wire
